// ===== pbp_asserts.sv
`timescale 1ns/10ps
module pbp_asserts (
    input wire CLK,
    input wire RST,
    input wire IN_RESET,
    input wire BUS_DRIVE,
    input wire BUS_WIDTH_STRAP,
    input wire [15:0] BUS_WR_DATA,
    input wire BUS_ACTIVE,
    input wire BUS_WIDE,
    input wire [7:0] PORT_A_O,
    input wire [7:0] PORT_A_OE,
    input wire [7:0] PORT_A_PU,
    input wire [7:0] PORT_B_O,
    input wire [7:0] PORT_B_OE,
    input wire [7:0] PORT_B_PU
);
    default clocking @(posedge CLK); endclocking
    ////////////////////////////////////////////////////////////////
    a_reset_flag: assert property (RST |=> IN_RESET)
        else $error("reset flag not raised");
    a_reset_quiet: assert property (IN_RESET && $past(IN_RESET) |->
        (PORT_A_OE | PORT_B_OE) == 8'h00 && !BUS_ACTIVE)
        else $error("pins driven in reset");
    a_narrow_bus: assert property (disable iff (RST) BUS_WIDTH_STRAP [*5] |-> !BUS_WIDE)
        else $error("wide bus with strap high");
    a_wide_bus: assert property (disable iff (RST)
        (!BUS_WIDTH_STRAP && BUS_ACTIVE) [*5] |-> BUS_WIDE)
        else $error("narrow bus with strap low");
    a_low_drive: assert property (disable iff (RST)
        BUS_ACTIVE && $past(BUS_ACTIVE) && BUS_DRIVE
        |=> PORT_A_OE == 8'hff && PORT_A_O == $past(BUS_WR_DATA[7:0]))
        else $error("low data byte not driven");
    a_high_drive: assert property (disable iff (RST)
        BUS_WIDE && BUS_ACTIVE && BUS_DRIVE
        |=> PORT_B_OE == 8'hff && PORT_B_O == $past(BUS_WR_DATA[15:8]))
        else $error("high data byte not driven");
    a_bus_pull_off: assert property (disable iff (RST) BUS_ACTIVE [*3] |-> PORT_A_PU == 8'h00)
        else $error("pull-up on bus pin");
    a_pull_inputs: assert property (disable iff (RST)
        (PORT_A_PU & PORT_A_OE) == 8'h00 && (PORT_B_PU & PORT_B_OE) == 8'h00)
        else $error("pull-up on output pin");
endmodule // pbp_asserts

// ===== pbp_defines.vh
// Functional notes
// - Port A has eight pins, each with its own direction bit set by software.
// - In single-chip operation pull-ups on input pins are enabled per group of four bits.
// - In bus operation pull-ups are ignored on bus pins but still work on general port pins.
// - The external data bus is 16 bits wide when the width strap is low, 8 bits when high.
// - A low mode strap starts single-chip or expansion operation, a high one microprocessor.
// - The block stays in reset while the active-low reset pin is held low.
// - On the separate bus port A carries the low data byte and port B the high data byte.
// - Ports B and C are eight-bit ports with the same direction and pull-up control as A.
// - Software can route the upper three pins of port B to external interrupt inputs.
`ifndef PBP_DEFINES_VH
`define PBP_DEFINES_VH

// Register byte addresses
`define PBP_DIR_A 8'h00
`define PBP_DIR_B 8'h04
`define PBP_DIR_C 8'h08
`define PBP_OUT_A 8'h0c
`define PBP_OUT_B 8'h10
`define PBP_OUT_C 8'h14
`define PBP_PIN_IN 8'h18
`define PBP_PULL 8'h1c
`define PBP_CTRL 8'h20
`define PBP_STATUS 8'h24
`define PBP_INT_STAT 8'h28
`define PBP_INT_MASK 8'h2c

// Control fields
`define PBP_CTRL_EXP 0
`define PBP_CTRL_INT_LO 1
`define PBP_CTRL_INT_HI 3

// Status fields
`define PBP_ST_MICRO 0
`define PBP_ST_BYTE8 1
`define PBP_ST_BUS 2

// Port B pins that may act as interrupts
`define PBP_INT_PIN_LO 5
`define PBP_INT_PIN_HI 7

// Reset values
`define PBP_DIR_RST 8'h00
`define PBP_OUT_RST 8'h00
`define PBP_PULL_RST 6'h00
`define PBP_CTRL_RST 4'h0
`define PBP_INT_RST 3'h0

// Bus responses
`define PBP_RESP_OKAY 2'b00
`define PBP_RESP_DECERR 2'b11

`endif

// ===== pbp_pins.sv
`timescale 1ns/10ps
module pbp_pins (
    input wire clk,
    input wire [23:0] o,
    input wire [23:0] oe,
    input wire [23:0] pu,
    input wire [23:0] drv_en,
    input wire [23:0] drv_val,
    output wire [23:0] pin
);
    reg [23:0] last_q = 24'h000000;
    // Floating pins wander so stale data never passes
    always @(posedge clk) begin
        last_q <= pin;
    end
    assign pin = (oe & o) | (~oe & drv_en & drv_val) | (~oe & ~drv_en & (pu | ~last_q));
endmodule // pbp_pins

// ===== pbp_ports.v
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "pbp_defines.vh"

module pbp_ports (
    input wire CLK,
    input wire RST,
    input wire RESET_PIN_N,
    input wire PROCESSOR_MODE_STRAP,
    input wire BUS_WIDTH_STRAP,
    input wire [7:0] PORT_A_I,
    output reg [7:0] PORT_A_O,
    output reg [7:0] PORT_A_OE,
    output reg [7:0] PORT_A_PU,
    input wire [7:0] PORT_B_I,
    output reg [7:0] PORT_B_O,
    output reg [7:0] PORT_B_OE,
    output reg [7:0] PORT_B_PU,
    input wire [7:0] PORT_C_I,
    output reg [7:0] PORT_C_O,
    output reg [7:0] PORT_C_OE,
    output reg [7:0] PORT_C_PU,
    input wire [15:0] BUS_WR_DATA,
    input wire BUS_DRIVE,
    output reg [15:0] BUS_RD_DATA,
    output reg BUS_ACTIVE,
    output reg BUS_WIDE,
    output reg IN_RESET,
    output reg IRQ,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);

////////////////////////////////////////////////////////////////////////////////

// Pull-up for one port: group bit per nibble, input pins only, not on bus pins
function [7:0] pull_en;
    input [7:0] dir;
    input [1:0] grp;
    input on_bus;
    begin
        pull_en = ~dir & {{4{grp[1]}}, {4{grp[0]}}} & {8{~on_bus}};
    end
endfunction

// True when address is a mapped register
function mapped;
    input [7:0] addr;
    begin
        mapped = (addr[1:0] == 2'b00) && (addr <= `PBP_INT_MASK);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

wire [26:0] sync_q;
wire [7:0] a_s;
wire [7:0] b_s;
wire [7:0] c_s;
wire mode_s;
wire byte_s;
wire rst_pin_n_s;

// Pins and straps cross into the clock domain here
pbp_sync #(
    .WIDTH(27),
    .INIT(27'h4000000)
) u_sync (
    .CLK(CLK),
    // Not reset: the mode strap must reach micro_q while reset is held
    .RST(1'b0),
    .D({RESET_PIN_N, BUS_WIDTH_STRAP, PROCESSOR_MODE_STRAP, PORT_C_I, PORT_B_I, PORT_A_I}),
    .Q(sync_q)
);

assign a_s = sync_q[7:0];
assign b_s = sync_q[15:8];
assign c_s = sync_q[23:16];
assign mode_s = sync_q[24];
assign byte_s = sync_q[25];
assign rst_pin_n_s = sync_q[26];

wire rst_all = RST | ~rst_pin_n_s;

////////////////////////////////////////////////////////////////////////////////

reg [7:0] dir_a_q;
reg [7:0] dir_b_q;
reg [7:0] dir_c_q;
reg [7:0] out_a_q;
reg [7:0] out_b_q;
reg [7:0] out_c_q;
reg [5:0] pull_q;
reg [3:0] ctrl_q;
reg [2:0] int_stat_q;
reg [2:0] int_mask_q;
reg [2:0] int_prev_q;
reg micro_q;
reg [7:0] aw_addr_q;
reg aw_have_q;
reg [31:0] w_data_q;
reg w_strb_q;
reg w_have_q;

wire bus_on = micro_q | ctrl_q[`PBP_CTRL_EXP];
wire wide = ~byte_s;
// high byte only in 16-bit width
wire b_on_bus = bus_on & wide;
wire [2:0] int_route = ctrl_q[`PBP_CTRL_INT_HI:`PBP_CTRL_INT_LO];

////////////////////////////////////////////////////////////////////////////////

// strap tracked while in reset, frozen at release
always @(posedge CLK) begin
    if (rst_all) begin
        micro_q <= mode_s;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Write channel: address and data taken in either order

wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
wire w_take = S_AXI_WVALID & S_AXI_WREADY;
wire wr_fire = aw_have_q & w_have_q & ~S_AXI_BVALID;
wire [7:0] wr_addr = aw_addr_q;
wire [31:0] wr_data = w_data_q;
// Registers are one byte wide, so only the low lane counts
wire wr_lo = w_strb_q;

always @(posedge CLK) begin
    if (rst_all) begin
        S_AXI_AWREADY <= 1'b0;
        S_AXI_WREADY <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        aw_addr_q <= 8'h00;
        w_data_q <= 32'h0;
        w_strb_q <= 1'b0;
        S_AXI_BVALID <= 1'b0;
        S_AXI_BRESP <= `PBP_RESP_OKAY;
    end else begin
        S_AXI_AWREADY <= ~aw_have_q & ~aw_take & ~S_AXI_BVALID;
        S_AXI_WREADY <= ~w_have_q & ~w_take & ~S_AXI_BVALID;
        if (aw_take) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
        end
        if (w_take) begin
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB[0];
        end
        if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= mapped(wr_addr) ? `PBP_RESP_OKAY : `PBP_RESP_DECERR;
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register file

always @(posedge CLK) begin
    if (rst_all) begin
        dir_a_q <= `PBP_DIR_RST;
        dir_b_q <= `PBP_DIR_RST;
        dir_c_q <= `PBP_DIR_RST;
        out_a_q <= `PBP_OUT_RST;
        out_b_q <= `PBP_OUT_RST;
        out_c_q <= `PBP_OUT_RST;
        pull_q <= `PBP_PULL_RST;
        ctrl_q <= `PBP_CTRL_RST;
        int_mask_q <= `PBP_INT_RST;
    end else if (wr_fire && wr_lo) begin
        case (wr_addr)
            `PBP_DIR_A: dir_a_q <= wr_data[7:0];
            // same control for ports B and C
            `PBP_DIR_B: dir_b_q <= wr_data[7:0];
            `PBP_DIR_C: dir_c_q <= wr_data[7:0];
            `PBP_OUT_A: out_a_q <= wr_data[7:0];
            `PBP_OUT_B: out_b_q <= wr_data[7:0];
            `PBP_OUT_C: out_c_q <= wr_data[7:0];
            // one pull bit per four pins
            `PBP_PULL: pull_q <= wr_data[5:0];
            `PBP_CTRL: ctrl_q <= wr_data[3:0];
            `PBP_INT_MASK: int_mask_q <= wr_data[2:0];
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// External interrupt inputs on upper port B pins

wire [2:0] int_pins = b_s[`PBP_INT_PIN_HI:`PBP_INT_PIN_LO];
// Falling edge taken as the event; the port still reads the pin as well
wire [2:0] int_evt = int_prev_q & ~int_pins & int_route;
wire [2:0] int_clr = (wr_fire && wr_lo && wr_addr == `PBP_INT_STAT) ? wr_data[2:0] : 3'h0;

always @(posedge CLK) begin
    if (rst_all) begin
        int_prev_q <= 3'h7;
        int_stat_q <= `PBP_INT_RST;
    end else begin
        int_prev_q <= int_pins;
        // routed pins set sticky status; set wins over clear
        int_stat_q <= (int_stat_q & ~int_clr) | int_evt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel

reg [31:0] rd_mux;

always @* begin
    rd_mux = 32'h0;
    case (S_AXI_ARADDR)
        `PBP_DIR_A: rd_mux = {24'h0, dir_a_q};
        `PBP_DIR_B: rd_mux = {24'h0, dir_b_q};
        `PBP_DIR_C: rd_mux = {24'h0, dir_c_q};
        `PBP_OUT_A: rd_mux = {24'h0, out_a_q};
        `PBP_OUT_B: rd_mux = {24'h0, out_b_q};
        `PBP_OUT_C: rd_mux = {24'h0, out_c_q};
        `PBP_PIN_IN: rd_mux = {8'h0, c_s, b_s, a_s};
        `PBP_PULL: rd_mux = {26'h0, pull_q};
        `PBP_CTRL: rd_mux = {28'h0, ctrl_q};
        `PBP_STATUS: rd_mux = {29'h0, bus_on, byte_s, micro_q};
        `PBP_INT_STAT: rd_mux = {29'h0, int_stat_q};
        `PBP_INT_MASK: rd_mux = {29'h0, int_mask_q};
        default: rd_mux = 32'h0;
    endcase
end

wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;

always @(posedge CLK) begin
    if (rst_all) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b0;
        S_AXI_RDATA <= 32'h0;
        S_AXI_RRESP <= `PBP_RESP_OKAY;
    end else begin
        S_AXI_ARREADY <= ~S_AXI_RVALID & ~ar_take;
        if (ar_take) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? `PBP_RESP_OKAY : `PBP_RESP_DECERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drive

reg [7:0] a_o_d;
reg [7:0] a_oe_d;
reg [7:0] b_o_d;
reg [7:0] b_oe_d;

always @* begin
    a_o_d = out_a_q;
    a_oe_d = dir_a_q;
    b_o_d = out_b_q;
    b_oe_d = dir_b_q;
    // port A low data byte, port B high data byte
    if (bus_on) begin
        a_o_d = BUS_WR_DATA[7:0];
        a_oe_d = {8{BUS_DRIVE}};
    end
    // port B stays a port in 8-bit width
    if (b_on_bus) begin
        b_o_d = BUS_WR_DATA[15:8];
        b_oe_d = {8{BUS_DRIVE}};
    end
end

always @(posedge CLK) begin
    if (rst_all) begin
        PORT_A_O <= 8'h00;
        PORT_A_OE <= 8'h00;
        PORT_A_PU <= 8'h00;
        PORT_B_O <= 8'h00;
        PORT_B_OE <= 8'h00;
        PORT_B_PU <= 8'h00;
        PORT_C_O <= 8'h00;
        PORT_C_OE <= 8'h00;
        PORT_C_PU <= 8'h00;
        BUS_RD_DATA <= 16'h0;
        BUS_ACTIVE <= 1'b0;
        BUS_WIDE <= 1'b0;
        IRQ <= 1'b0;
    end else begin
        PORT_A_O <= a_o_d;
        PORT_A_OE <= a_oe_d;
        PORT_B_O <= b_o_d;
        PORT_B_OE <= b_oe_d;
        PORT_C_O <= out_c_q;
        PORT_C_OE <= dir_c_q;
        // bus pins lose pull-ups, port pins keep them
        PORT_A_PU <= pull_en(dir_a_q, pull_q[1:0], bus_on);
        PORT_B_PU <= pull_en(dir_b_q, pull_q[3:2], b_on_bus);
        PORT_C_PU <= pull_en(dir_c_q, pull_q[5:4], 1'b0);
        BUS_RD_DATA <= {b_on_bus ? b_s : 8'h00, a_s};
        BUS_ACTIVE <= bus_on;
        BUS_WIDE <= wide;
        IRQ <= |(int_stat_q & int_mask_q);
    end
end

// Reset indication registered apart so it is driven during reset too
always @(posedge CLK) begin
    IN_RESET <= rst_all;
end

endmodule // pbp_ports

// ===== pbp_sync.v
`timescale 1ns/10ps
// Two-flop synchroniser; first stage feeds only the second
module pbp_sync #(
    parameter WIDTH = 27,
    parameter [26:0] INIT = 27'h0
) (
    input wire CLK,
    input wire RST,
    input wire [WIDTH-1:0] D,
    output reg [WIDTH-1:0] Q
);

reg [WIDTH-1:0] meta_q;

always @(posedge CLK) begin
    if (RST) begin
        meta_q <= INIT[WIDTH-1:0];
        Q <= INIT[WIDTH-1:0];
    end else begin
        meta_q <= D;
        Q <= meta_q;
    end
end

endmodule // pbp_sync

// ===== pbp_tb.sv
`timescale 1ns/10ps
`include "pbp_defines.vh"
module tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg rst_pin_n = 1'b1;
    reg mode_strap = 1'b0;
    reg width_strap = 1'b1;
    reg [15:0] wr_data = 16'h0000;
    reg bus_drive = 1'b0;
    reg [7:0] awaddr = 8'h00;
    reg [7:0] araddr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    reg [23:0] ext_en = 24'hffffff;
    reg [23:0] ext_val = 24'h96c35a;
    wire [23:0] o, oe, pu, pin;
    wire [15:0] rd_data;
    wire bus_active, bus_wide, in_reset, irq, awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer miscompares = 0;
    integer tests_run = 0;
    reg [7:0] x;
    reg [31:0] v;
    reg [1:0] r;
    always #12.5 clk = ~clk;
    pbp_pins u_pins (.clk(clk), .o(o), .oe(oe), .pu(pu), .drv_en(ext_en), .drv_val(ext_val),
        .pin(pin));
    pbp_ports u_dut (.CLK(clk), .RST(rst), .RESET_PIN_N(rst_pin_n),
        .PROCESSOR_MODE_STRAP(mode_strap), .BUS_WIDTH_STRAP(width_strap),
        .PORT_A_I(pin[7:0]), .PORT_A_O(o[7:0]), .PORT_A_OE(oe[7:0]), .PORT_A_PU(pu[7:0]),
        .PORT_B_I(pin[15:8]), .PORT_B_O(o[15:8]), .PORT_B_OE(oe[15:8]), .PORT_B_PU(pu[15:8]),
        .PORT_C_I(pin[23:16]), .PORT_C_O(o[23:16]), .PORT_C_OE(oe[23:16]),
        .PORT_C_PU(pu[23:16]), .BUS_WR_DATA(wr_data), .BUS_DRIVE(bus_drive),
        .BUS_RD_DATA(rd_data), .BUS_ACTIVE(bus_active), .BUS_WIDE(bus_wide),
        .IN_RESET(in_reset), .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    ////////////////////////////////////////////////////////////////
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid);
            bready <= 1'b0;
            r = bresp;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge clk);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            rready <= 1'b0;
            v = rdata;
            r = rresp;
        end
    endtask
    task give_verdict;
        begin
            $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        miscompares = miscompares + 1;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge clk);
        chk(in_reset, 1'b1);
        chk(bus_active, 1'b0);
        rst <= 1'b0;
        for (x = 0; x < 12; x = x + 1) begin
            rd(x * 8'h04);
            if (x != 6 && x != 9) chk(v, 32'h0);
            if (x == 6) chk(v, {8'h00, ext_val});
            if (x == 9) chk(v, 32'h2);
        end
        rd(8'h30);
        chk(r, `PBP_RESP_DECERR);
        wr(8'h31, 32'h1);
        chk(r, `PBP_RESP_DECERR);
        for (x = 0; x < 3; x = x + 1) begin
            wr(`PBP_DIR_A + x * 8'h04, 8'h1c ^ x);
            chk(r, `PBP_RESP_OKAY);
            wr(`PBP_OUT_A + x * 8'h04, 8'h40 + x * 8'h11);
        end
        repeat (2) @(posedge clk);
        for (x = 0; x < 3; x = x + 1) begin
            chk(oe[8*x+:8], 8'h1c ^ x);
            chk(o[8*x+:8], 8'h40 + x * 8'h11);
        end
        rd(`PBP_PIN_IN);
        chk(v, {8'h00, (24'h625140 & 24'h1e1d1c) | (ext_val & ~24'h1e1d1c)});
        ext_en <= 24'h000000;
        wr(`PBP_PULL, 32'h19);
        repeat (2) @(posedge clk);
        chk(pu, 24'h0ff00f & ~24'h1e1d1c);
        wr(`PBP_CTRL, 32'h1);
        bus_drive <= 1'b1;
        wr_data <= 16'h5aa5;
        ext_en <= 24'hffffff;
        repeat (3) @(posedge clk);
        chk(oe[15:0], 16'h1dff);
        chk(o[7:0], 8'ha5);
        chk(pu, 24'h0ff00f & ~24'h1e1d1c & 24'hffff00);
        chk(bus_wide, 1'b0);
        chk(bus_active, 1'b1);
        rd(`PBP_STATUS);
        chk(v, 32'h6);
        chk(r, `PBP_RESP_OKAY);
        bus_drive <= 1'b0;
        ext_val <= 24'h96e35a;
        repeat (5) @(posedge clk);
        chk(rd_data, 16'h005a);
        wr(`PBP_INT_MASK, 32'h2);
        wr(`PBP_CTRL, 32'h7);
        ext_val <= 24'h96035a;
        repeat (6) @(posedge clk);
        rd(`PBP_INT_STAT);
        chk(v, 32'h3);
        chk(irq, 1'b1);
        wr(`PBP_INT_STAT, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rd(`PBP_INT_STAT);
        chk(v, 32'h1);
        rst_pin_n <= 1'b0;
        mode_strap <= 1'b1;
        width_strap <= 1'b0;
        repeat (6) @(posedge clk);
        chk(in_reset, 1'b1);
        chk(oe, 24'h000000);
        rst_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(`PBP_STATUS);
        chk(v, 32'h5);
        chk(bus_wide, 1'b1);
        bus_drive <= 1'b1;
        wr_data <= 16'h1234;
        repeat (2) @(posedge clk);
        chk({oe[15:0], o[15:0]}, 32'hffff1234);
        bus_drive <= 1'b0;
        repeat (5) @(posedge clk);
        chk(rd_data, ext_val[15:0]);
        // Plain reset must also pick up the high mode strap
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(`PBP_STATUS);
        chk(v, 32'h5);
        give_verdict;
    end
endmodule // tb
bind pbp_ports pbp_asserts u_chk (.CLK(CLK), .RST(RST), .IN_RESET(IN_RESET),
    .BUS_DRIVE(BUS_DRIVE), .BUS_WIDTH_STRAP(BUS_WIDTH_STRAP), .BUS_WR_DATA(BUS_WR_DATA),
    .BUS_ACTIVE(BUS_ACTIVE), .BUS_WIDE(BUS_WIDE), .PORT_A_O(PORT_A_O), .PORT_A_OE(PORT_A_OE),
    .PORT_A_PU(PORT_A_PU), .PORT_B_O(PORT_B_O), .PORT_B_OE(PORT_B_OE), .PORT_B_PU(PORT_B_PU));
